/* File: hw/lockcmd_cfg.svh */
// Constants for the lock, reset and key command interpreter.
`ifndef LOCKCMD_CFG_SVH
`define LOCKCMD_CFG_SVH
`define OPC_READ_LOCK   8'h3d
`define OPC_GLOBAL_LOCK 8'h7e
`define OPC_GLOBAL_UNLK 8'h98
`define OPC_RST_ENABLE  8'h66
`define OPC_RST_DEVICE  8'h99
`define OPC_KEY_CMD     8'h9b
`define SUB_ROOT_KEY    8'h00
`define SUB_HMAC_KEY    8'h01
`define LOCK_CNT        16
`define LOCK_IDX_LSB    16
`define CTR_CNT         8'h04
`define ROOT_OP_BYTES   7'd64
`define HMAC_OP_BYTES   7'd40
`define KEY_FIRST_BYTE  7'd4
`define KEY_LAST_BYTE   7'd35
`define ST_RESET_VAL    8'h00
`define ST_OK           8'h80
`define ST_ERR_ARG      8'h04
`define ST_ERR_STATE    8'h08
`define ST_ERR_SIG      8'h02
`define CLK_PERIOD_NS   10
`define RST_TIME_NS     30000
`define RST_CYC         ((`RST_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POLL_DELAY_NS   1000
`define POLL_CYC        (`POLL_DELAY_NS / `CLK_PERIOD_NS)
`endif

/* File: hw/lockcmd_pkg.sv */
// Types for the lock, reset and key command interpreter.
package lockcmd_pkg;
  typedef enum logic [5:0] {
    S_IDLE   = 6'b000001,
    S_OPC    = 6'b000010,
    S_ADDR   = 6'b000100,
    S_READ   = 6'b001000,
    S_KEY    = 6'b010000,
    S_IGNORE = 6'b100000
  } frame_e;
  typedef logic [7:0] byte_t;
endpackage

/* File: hw/flash_lock_reset_key_commands.sv */
// Serial flash command handling for lock bits, reset and key commands.
`timescale 1ns/1ps
`include "lockcmd_cfg.svh"

// Behaviour
// - Lock bits protect only when scheme select set
// - Lock bits volatile, all set after reset
// - 3Dh plus address returns lock byte MSB-first
// - Lock byte LSB one means locked
// - Four-byte mode uses 32-bit lock read address
// - Bare 7Eh sets all lock bits
// - Bare 98h clears all lock bits
// - Accepted reset restores power-on volatile defaults
// - Reset needs 66h then 99h next
// - Other command after 66h cancels reset enable
// - Reject all commands for 30us after reset
// - 9Bh 00h loads addressed root key
// - Root write checks 64-byte operand, counter range
// - Root write needs uninitialized root state
// - Truncated signature mismatch rejects transaction
// - Success reported, init state cleared last; here both on the same edge
// - All-ones key only zeroes uninitialized counter
// - Initialized root key refuses writes, never read
// - 9Bh 01h replaces volatile HMAC key
// - HMAC update busy twice polling delay
// - HMAC update checks size, range, init, signature
// - Failed checks post error, success posts OK
module flash_lock_reset_key_commands
  import lockcmd_pkg::*;
(
  // Clock, reset and clock enable.
  input  wire logic        CLOCK_I,
  input  wire logic        RST_I,
  input  wire logic        CE_I,
  // Serial bus pins.
  input  wire logic        SCK_I,
  input  wire logic        CS_N_I,
  input  wire logic        MOSI_I,
  output logic             MISO_O,
  output logic             MISO_OE_O,
  // Protection configuration.
  input  wire logic        ADDR4_MODE_I,
  input  wire logic        PROTECT_SCHEME_SELECT_I,
  input  wire logic        PROTECT_COMPLEMENT_I,
  input  wire logic        PROTECT_TOP_BOTTOM_I,
  input  wire logic [3:0]  BLOCK_PROTECT_FIELD_I,
  input  wire logic [3:0]  PROT_BLOCK_I,
  output logic             WRITE_PROTECT_O,
  // Device state.
  output logic             BUSY_O,
  output logic             DEVICE_RESET_O,
  // Key engine handshake.
  input  wire logic        SIG_MATCH_I,
  output logic [7:0]       COUNTER_STATUS_O,
  output logic             ROOT_KEY_LOAD_O,
  output logic             HMAC_UPDATE_O,
  output logic             COUNTER_ZERO_O,
  output logic [1:0]       COUNTER_IDX_O
);

  // Block-protect decode, used when the lock bits are not selected.
  // Field codes above five cover the whole sixteen-block map.
  function automatic logic bp_protects(input logic [3:0] bp,
                                       input logic       top,
                                       input logic       cmp,
                                       input logic [3:0] idx);
    logic [4:0] n;
    logic       hit;
    n = (bp == 4'h0) ? 5'd0 :
        (bp > 4'h5) ? 5'd16 : 5'(5'd1 << (bp - 4'h1));
    hit = top ? ({1'b0, idx} >= 5'(5'd16 - n)) : ({1'b0, idx} < n);
    bp_protects = hit ^ cmp;
  endfunction

  // Pin synchronisers; the first stage feeds only the second.
  logic       sck_s1_q, sck_s2_q, sck_s3_q;
  logic       cs_s1_q, cs_s2_q, cs_s3_q;
  logic       mosi_s1_q, mosi_s2_q;

  frame_e     state_q;
  logic [2:0] bit_q;
  byte_t      in_q;
  byte_t      out_q;
  logic [6:0] bcnt_q;
  logic [2:0] acnt_q;
  logic [31:0] addr_q;
  byte_t      op_q;
  byte_t      sub_q;
  byte_t      ctr_q;
  logic       key_ones_q;
  logic       bare_ok_q;
  logic       rst_en_q;
  logic [12:0] busy_cnt_q;
  logic [`LOCK_CNT-1:0] lock_q;
  logic [3:0] root_uninit_q;
  logic [3:0] mc_uninit_q;

  wire        sck_rise = sck_s2_q & ~sck_s3_q;
  wire        sck_fall = ~sck_s2_q & sck_s3_q;
  wire        cs_fall  = ~cs_s2_q & cs_s3_q;
  wire        cs_rise  = cs_s2_q & ~cs_s3_q;
  wire        sel      = ~cs_s2_q;
  wire        bit_in   = sel & sck_rise;
  wire        byte_done = bit_in & (bit_q == 3'd7);
  wire byte_t rx_byte  = {in_q[6:0], mosi_s2_q};
  wire [2:0]  addr_len = ADDR4_MODE_I ? 3'd4 : 3'd3;
  wire [31:0] addr_nx  = {addr_q[23:0], rx_byte};
  // The block index is taken from read address bits 19:16 in either address mode.
  wire [3:0]  lock_idx = addr_nx[`LOCK_IDX_LSB +: 4];
  wire        busy     = (busy_cnt_q != 13'd0);
  wire        ends_ok  = cs_rise & bare_ok_q & (bit_q == 3'd0);
  wire        do_glock = ends_ok & (op_q == `OPC_GLOBAL_LOCK);
  wire        do_gunlk = ends_ok & (op_q == `OPC_GLOBAL_UNLK);
  wire        do_rsten = ends_ok & (op_q == `OPC_RST_ENABLE);
  wire        do_reset = ends_ok & rst_en_q &
                         (op_q == `OPC_RST_DEVICE);
  wire        key_end  = cs_rise & (state_q == S_KEY) &
                         (bit_q == 3'd0);
  wire        is_root  = (sub_q == `SUB_ROOT_KEY);
  wire        is_hmac  = (sub_q == `SUB_HMAC_KEY);
  wire        ctr_ok   = (ctr_q < `CTR_CNT);
  wire [1:0]  ci       = ctr_q[1:0];
  wire        root_sz  = (bcnt_q == `ROOT_OP_BYTES);
  wire        hmac_sz  = (bcnt_q == `HMAC_OP_BYTES);

  // Root key write: size and range first, then state, then signature.
  wire        root_arg = ~root_sz | ~ctr_ok;
  wire        root_st  = ~root_uninit_q[ci];
  wire        root_ok  = ~root_arg & ~root_st & SIG_MATCH_I;
  wire        hmac_arg = ~hmac_sz | ~ctr_ok;
  wire        hmac_st  = mc_uninit_q[ci];
  wire        hmac_ok  = ~hmac_arg & ~hmac_st & SIG_MATCH_I;

  wire byte_t key_status =
    is_root ? (root_arg ? `ST_ERR_ARG : root_st ? `ST_ERR_STATE :
               SIG_MATCH_I ? `ST_OK : `ST_ERR_SIG) :
    is_hmac ? (hmac_arg ? `ST_ERR_ARG : hmac_st ? `ST_ERR_STATE :
               SIG_MATCH_I ? `ST_OK : `ST_ERR_SIG) :
    `ST_ERR_ARG;

  wire        root_done = key_end & is_root & root_ok;
  wire        hmac_done = key_end & is_hmac & hmac_ok;

  // One load point for the busy timer; a reset outranks key work.
  // Frames that begin while the timer runs are ignored entirely, so a
  // host that does not poll busy loses commands rather than corrupting.
  wire [12:0] busy_load =
    do_reset  ? 13'(`RST_CYC) :
    hmac_done ? 13'(2 * `POLL_CYC) :
    root_done ? 13'(`POLL_CYC) : 13'd0;

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      sck_s1_q  <= 1'b0;
      sck_s2_q  <= 1'b0;
      sck_s3_q  <= 1'b0;
      cs_s1_q   <= 1'b1;
      cs_s2_q   <= 1'b1;
      cs_s3_q   <= 1'b1;
      mosi_s1_q <= 1'b0;
      mosi_s2_q <= 1'b0;
    end else if (CE_I) begin
      sck_s1_q  <= SCK_I;
      sck_s2_q  <= sck_s1_q;
      sck_s3_q  <= sck_s2_q;
      cs_s1_q   <= CS_N_I;
      cs_s2_q   <= cs_s1_q;
      cs_s3_q   <= cs_s2_q;
      mosi_s1_q <= MOSI_I;
      mosi_s2_q <= mosi_s1_q;
    end
  end

  // Frame decoder: opcodes and address on rising bus clock edges.
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      state_q    <= S_IDLE;
      bit_q      <= 3'd0;
      in_q       <= 8'h00;
      bcnt_q     <= 7'd0;
      acnt_q     <= 3'd0;
      addr_q     <= 32'h0;
      op_q       <= 8'h00;
      sub_q      <= 8'h00;
      ctr_q      <= 8'h00;
      key_ones_q <= 1'b1;
      bare_ok_q  <= 1'b0;
    end else if (CE_I) begin
      if (cs_fall) begin
        state_q   <= busy ? S_IGNORE : S_OPC;
        bit_q     <= 3'd0;
        bcnt_q    <= 7'd0;
        acnt_q    <= 3'd0;
        bare_ok_q <= 1'b0;
        key_ones_q <= 1'b1;
      end else if (cs_rise) begin
        state_q   <= S_IDLE;
      end else if (bit_in) begin
        bit_q <= 3'(bit_q + 3'd1);
        in_q  <= rx_byte;
        if (state_q != S_OPC) begin
          bare_ok_q <= 1'b0;
        end
        if (bit_q == 3'd7) begin
          unique case (state_q)
            S_OPC: begin
              op_q      <= rx_byte;
              bare_ok_q <= 1'b1;
              if (rx_byte == `OPC_READ_LOCK) begin
                state_q <= S_ADDR;
              end else if (rx_byte == `OPC_KEY_CMD) begin
                state_q <= S_KEY;
              end else begin
                state_q <= S_IGNORE;
              end
            end
            S_ADDR: begin
              addr_q <= addr_nx;
              acnt_q <= 3'(acnt_q + 3'd1);
              if (3'(acnt_q + 3'd1) == addr_len) begin
                state_q <= S_READ;
              end
            end
            S_KEY: begin
              if (bcnt_q != 7'h7f) begin
                bcnt_q <= 7'(bcnt_q + 7'd1);
              end
              if (bcnt_q == 7'd0) begin
                sub_q <= rx_byte;
              end
              if (bcnt_q == 7'd1) begin
                ctr_q <= rx_byte;
              end
              if (bcnt_q >= `KEY_FIRST_BYTE &&
                  bcnt_q <= `KEY_LAST_BYTE &&
                  rx_byte != 8'hff) begin
                key_ones_q <= 1'b0;
              end
            end
            S_READ, S_IGNORE, S_IDLE: begin
            end
          endcase
        end
      end
    end
  end

  // Lock byte goes out on falling edges, repeating while selected.
  // The first bit leaves on the fall that ends the last address bit.
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      out_q     <= 8'h00;
      MISO_O    <= 1'b0;
      MISO_OE_O <= 1'b0;
    end else if (CE_I) begin
      if (byte_done && state_q == S_ADDR &&
          3'(acnt_q + 3'd1) == addr_len) begin
        out_q <= {7'h00, lock_q[lock_idx]};
      end else if (sel && sck_fall && state_q == S_READ) begin
        MISO_O    <= out_q[7];
        MISO_OE_O <= 1'b1;
        out_q     <= {out_q[6:0], out_q[7]};
      end
      if (cs_rise) begin
        MISO_OE_O <= 1'b0;
      end
    end
  end

  // Lock bits, reset sequencing and busy timer.
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      lock_q         <= '1;
      rst_en_q       <= 1'b0;
      busy_cnt_q     <= 13'd0;
      BUSY_O         <= 1'b0;
      DEVICE_RESET_O <= 1'b0;
      WRITE_PROTECT_O <= 1'b1;
    end else if (CE_I) begin
      DEVICE_RESET_O <= do_reset;
      if (do_reset) begin
        lock_q <= '1;
      end else if (do_glock) begin
        lock_q <= '1;
      end else if (do_gunlk) begin
        lock_q <= '0;
      end
      // Any completed frame other than enable-reset drops the armed state.
      if (do_reset) begin
        rst_en_q <= 1'b0;
      end else if (do_rsten) begin
        rst_en_q <= 1'b1;
      end else if (cs_rise && state_q != S_IGNORE) begin
        rst_en_q <= 1'b0;
      end else if (cs_rise && op_q != `OPC_RST_ENABLE) begin
        rst_en_q <= 1'b0;
      end
      if (busy_load != 13'd0) begin
        busy_cnt_q <= busy_load;
      end else if (busy) begin
        busy_cnt_q <= 13'(busy_cnt_q - 13'd1);
      end
      BUSY_O <= (busy_load != 13'd0) | (busy_cnt_q > 13'd1);
      WRITE_PROTECT_O <= PROTECT_SCHEME_SELECT_I ?
        lock_q[PROT_BLOCK_I] :
        bp_protects(BLOCK_PROTECT_FIELD_I, PROTECT_TOP_BOTTOM_I,
                    PROTECT_COMPLEMENT_I, PROT_BLOCK_I);
    end
  end

  // Counter key state; the root key itself is never sent back out.
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      root_uninit_q    <= '1;
      mc_uninit_q      <= '1;
      COUNTER_STATUS_O <= `ST_RESET_VAL;
      ROOT_KEY_LOAD_O  <= 1'b0;
      HMAC_UPDATE_O    <= 1'b0;
      COUNTER_ZERO_O   <= 1'b0;
      COUNTER_IDX_O    <= 2'd0;
    end else if (CE_I) begin
      // Zeroing fires for any accepted root write, but only once per
      // counter, since its uninitialised flag clears on the same edge.
      // The root flag clears on the same edge as the status and the counter flag.
      ROOT_KEY_LOAD_O <= root_done & ~key_ones_q;
      HMAC_UPDATE_O   <= hmac_done;
      COUNTER_ZERO_O  <= root_done & mc_uninit_q[ci];
      if (key_end) begin
        COUNTER_STATUS_O <= key_status;
        COUNTER_IDX_O    <= ci;
      end
      if (root_done) begin
        mc_uninit_q[ci] <= 1'b0;
        if (!key_ones_q) begin
          root_uninit_q[ci] <= 1'b0;
        end
      end
    end
  end

endmodule

/* File: tb/lockcmd_host_model.sv */
// Serial flash controller model that frames commands on the bus pins.
`timescale 1ns/1ps
module lockcmd_host_model (
  // Clock and returned data.
  input  wire logic CLOCK_I,
  input  wire logic MISO_I,
  // Bus pins driven towards the device.
  output logic      SCK_O,
  output logic      CS_N_O,
  output logic      MOSI_O
);
  logic [7:0] rx_q;
  initial begin
    SCK_O = 1'b0;
    CS_N_O = 1'b1;
    MOSI_O = 1'b0;
    rx_q = 8'h00;
  end
  task automatic half(input int n);
    repeat (n) @(negedge CLOCK_I);
  endtask
  // Sends the low n bits of v MSB first, then clocks rd bits back.
  task automatic frame(input logic [519:0] v, input int n, input int rd);
    CS_N_O = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      MOSI_O = v[i];
      half(4);
      SCK_O = 1'b1;
      half(4);
      SCK_O = 1'b0;
    end
    repeat (rd) begin
      half(6);
      SCK_O = 1'b1;
      rx_q = {rx_q[6:0], MISO_I};
      half(4);
      SCK_O = 1'b0;
    end
    half(6);
    CS_N_O = 1'b1;
    // A released data line must not keep showing the last bit.
    MOSI_O = ~MOSI_O;
    half(8);
  endtask
endmodule

/* File: tb/lockcmd_monitor.sv */
// Timing checks on the ports of the lock, reset and key command block.
`timescale 1ns/1ps
`include "lockcmd_cfg.svh"
module lockcmd_monitor (
  // Watched ports.
  input logic       CLOCK_I,
  input logic       RST_I,
  input logic       SCK_I,
  input logic       CS_N_I,
  input logic       MISO_O,
  input logic       MISO_OE_O,
  input logic       PROTECT_SCHEME_SELECT_I,
  input logic       WRITE_PROTECT_O,
  input logic       BUSY_O,
  input logic       DEVICE_RESET_O,
  input logic       HMAC_UPDATE_O,
  input logic       ROOT_KEY_LOAD_O,
  input logic       COUNTER_ZERO_O,
  input logic [7:0] COUNTER_STATUS_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  logic [11:0] bcnt_q;
  logic [11:0] bcnt_d;
  logic        rs_q;
  logic        rs_d;
  logic        hm_q;
  logic        hm_d;
  // Busy length and the command that started it.
  assign bcnt_d = BUSY_O ? bcnt_q + 12'h001 : 12'h000;
  assign rs_d = DEVICE_RESET_O | (rs_q & BUSY_O);
  assign hm_d = HMAC_UPDATE_O | (hm_q & BUSY_O);
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      bcnt_q <= 12'h000;
      rs_q <= 1'b0;
      hm_q <= 1'b0;
    end else begin
      bcnt_q <= bcnt_d;
      rs_q <= rs_d;
      hm_q <= hm_d;
    end
  end
  chk_reset_len: assert property (
    $fell(BUSY_O) && rs_q |-> bcnt_q inside {[12'd2995:12'd3005]})
    else $error("reset busy time wrong");
  chk_hmac_len: assert property (
    $fell(BUSY_O) && hm_q |-> bcnt_q inside {[12'd198:12'd202]})
    else $error("key update busy time wrong");
  chk_busy_refuse: assert property (
    $past(BUSY_O) |-> !DEVICE_RESET_O)
    else $error("reset taken while busy");
  chk_wp_reset: assert property (
    DEVICE_RESET_O ##1 PROTECT_SCHEME_SELECT_I [*2] |=> WRITE_PROTECT_O)
    else $error("block not protected after reset");
  chk_oe_release: assert property (
    CS_N_I [*8] |-> !MISO_OE_O)
    else $error("data out driven while deselected");
  chk_miso_edge: assert property (
    MISO_OE_O && $changed(MISO_O) |-> !SCK_I && !$past(SCK_I, 2))
    else $error("data out moved outside clock low");
  chk_root_status: assert property (
    ROOT_KEY_LOAD_O |-> ##[0:250] COUNTER_STATUS_O == `ST_OK)
    else $error("root load without ok status");
  chk_hmac_status: assert property (
    HMAC_UPDATE_O |-> ##[0:250] COUNTER_STATUS_O == `ST_OK)
    else $error("key update without ok status");
  chk_zero_status: assert property (
    COUNTER_ZERO_O |-> COUNTER_STATUS_O == `ST_OK)
    else $error("counter zeroed without ok status");
endmodule
bind flash_lock_reset_key_commands lockcmd_monitor u_mon (.*);

/* File: tb/flash_lock_reset_key_commands_tb_top.sv */
// Self-checking bench for the lock, reset and key command block.
`timescale 1ns/1ps
module flash_lock_reset_key_commands_tb_top;
  import lockcmd_pkg::*;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         a4 = 1'b0;
  logic         sel = 1'b1;
  logic         sig = 1'b1;
  logic         sck, cs_n, mosi, miso, wp, busy;
  byte_t        st;
  logic [9:0]   nq[$];
  logic [255:0] k;
  int           num_errors = 0;
  int           samples_checked = 0;
  int           seed = 38;
  event         got;
  always #5 clk = ~clk;
  lockcmd_host_model u_host (.CLOCK_I(clk), .MISO_I(miso), .SCK_O(sck),
    .CS_N_O(cs_n), .MOSI_O(mosi));
  flash_lock_reset_key_commands u_dut (.CLOCK_I(clk), .RST_I(rst),
    .CE_I(1'b1), .SCK_I(sck), .CS_N_I(cs_n), .MOSI_I(mosi), .MISO_O(miso),
    .MISO_OE_O(), .ADDR4_MODE_I(a4), .PROTECT_SCHEME_SELECT_I(sel),
    .PROTECT_COMPLEMENT_I(1'b0), .PROTECT_TOP_BOTTOM_I(1'b0),
    .BLOCK_PROTECT_FIELD_I(4'h0), .PROT_BLOCK_I(4'h3),
    .WRITE_PROTECT_O(wp), .BUSY_O(busy), .DEVICE_RESET_O(),
    .SIG_MATCH_I(sig), .COUNTER_STATUS_O(st), .ROOT_KEY_LOAD_O(),
    .HMAC_UPDATE_O(), .COUNTER_ZERO_O(), .COUNTER_IDX_O());
  task automatic check_byte(input string nm, input byte_t e, g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic note(input logic [1:0] kd, input byte_t v);
    nq.push_back({kd, v});
  endtask
  // Sends a frame, then waits out the busy time before the next one.
  task automatic run(input logic [519:0] v, input int n, input int rd);
    int i;
    u_host.frame(v, n, rd);
    i = 0;
    while (busy !== 1'b0 && i < 4000) begin
      @(negedge clk);
      i++;
    end
    if (i == 4000)
      num_errors++;
    if (nq.size() != 0)
      -> got;
    @(negedge clk);
  endtask
  // The protect output is registered, so let it settle before looking.
  task automatic chk_wp(input byte_t e);
    note(2'd2, e);
    repeat (2) @(negedge clk);
    -> got;
    @(negedge clk);
  endtask
  task automatic rdlk(input byte_t e);
    note(2'd0, e);
    if (a4)
      run({8'h3d, 32'h0003_0000}, 40, 8);
    else
      run({8'h3d, 24'h03_0000}, 32, 8);
  endtask
  task automatic keyc(input byte_t s, c, input int n, input byte_t e);
    note(2'd1, e);
    run({8'h9b, s, c, 16'h0, k, k[223:0]} >> (520 - n), n, 0);
  endtask
  always @(got) begin
    logic [9:0] n;
    n = nq.pop_front();
    case (n[9:8])
      2'd0: check_byte("lock byte", n[7:0], u_host.rx_q);
      2'd1: check_byte("status", n[7:0], st);
      default: check_byte("protect", n[7:0], {7'h0, wp});
    endcase
  end
  initial begin
    #900000;
    num_errors++;
    give_verdict();
  end
  initial begin
    for (int i = 0; i < 8; i++)
      k[i*32 +: 32] = $random(seed);
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    chk_wp(8'h01);
    rdlk(8'h01);
    run(8'h98, 8, 0);
    rdlk(8'h00);
    chk_wp(8'h00);
    a4 = 1'b1;
    rdlk(8'h00);
    a4 = 1'b0;
    run(8'h7e, 8, 0);
    rdlk(8'h01);
    $display("lock tests done");
    run(8'h98, 8, 0);
    run(8'h66, 8, 0);
    rdlk(8'h00);
    run(8'h99, 8, 0);
    rdlk(8'h00);
    run(8'h66, 8, 0);
    u_host.frame(8'h99, 8, 0);
    run(8'h98, 8, 0);
    rdlk(8'h01);
    sel = 1'b0;
    chk_wp(8'h00);
    sel = 1'b1;
    $display("reset tests done");
    keyc(8'h00, 8'h00, 512, 8'h04);
    keyc(8'h00, 8'h04, 520, 8'h04);
    keyc(8'h02, 8'h00, 520, 8'h04);
    keyc(8'h01, 8'h00, 328, 8'h08);
    sig = 1'b0;
    keyc(8'h00, 8'h00, 520, 8'h02);
    sig = 1'b1;
    keyc(8'h00, 8'h00, 520, 8'h80);
    keyc(8'h00, 8'h00, 520, 8'h08);
    keyc(8'h01, 8'h00, 328, 8'h80);
    keyc(8'h01, 8'h00, 320, 8'h04);
    k = {256{1'b1}};
    keyc(8'h00, 8'h01, 520, 8'h80);
    k[7:0] = 8'h5a;
    keyc(8'h00, 8'h01, 520, 8'h80);
    $display("key tests done");
    give_verdict();
  end
endmodule
